// File: dv/sar_adc_sequencer_tb.sv
// self-checking testbench for the converter sequencer
`timescale 1ns/1ns
`default_nettype none
module sar_adc_sequencer_tb;
	import sar_adc_pkg::*;
	logic clk, reset, pin_cfg_write, go_set, go_clear, result_write, conv_done_clear;
	logic special_event, comparator_in, go_done, conv_done_flag, timer_reset;
	logic sample_enable, discharge, portb_analog_reset_select;
	logic [3:0] pin_cfg_wdata, pin_analog_config, channel_out;
	logic [9:0] dac_code, target;
	logic [12:0] port_pins, port_read_data;
	cfg_type cfg;
	result_type result_wdata, result;
	int failures = 0;
	int n_tests = 0;
	sar_adc_sequencer u_dut (.clk(clk), .reset(reset), .cfg(cfg),
		.portb_analog_reset_select(portb_analog_reset_select), .pin_cfg_write(pin_cfg_write),
		.pin_cfg_wdata(pin_cfg_wdata), .pin_analog_config(pin_analog_config),
		.go_set(go_set), .go_clear(go_clear), .go_done(go_done),
		.result_write(result_write), .result_wdata(result_wdata), .result(result),
		.conv_done_clear(conv_done_clear), .conv_done_flag(conv_done_flag),
		.special_event(special_event), .timer_reset(timer_reset),
		.comparator_in(comparator_in), .dac_code(dac_code), .channel_out(channel_out),
		.sample_enable(sample_enable), .discharge(discharge),
		.port_pins(port_pins), .port_read_data(port_read_data));
	// ---------------------------------------------------------------
	// clock, analog input model, checks
	// ---------------------------------------------------------------
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) comparator_in <= (target >= dac_code);
	task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic idle;
		int i;
		for (i = 0; i < 2000 && !(sample_enable === 1 && discharge === 0); i++) @(negedge clk);
	endtask
	task automatic pulse_go;
		@(posedge clk) go_set <= 1;
		@(posedge clk) go_set <= 0;
	endtask
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic run_conv(logic [2:0] acq, int acq_n, logic [2:0] cs, int bit_period, logic fmt);
		int n, m, ex;
		@(posedge clk) begin
			cfg.acq_time_select <= acq;
			cfg.conv_clock_select <= cs;
			cfg.result_format <= fmt;
		end
		idle();
		pulse_go();
		n = 1;
		for (int i = 0; i < 8000 && conv_done_flag !== 1; i++) begin
			@(negedge clk);
			n++;
		end
		ex = acq_n * bit_period + 11 * bit_period + 1 + ((acq == 0 && cs[1:0] == 2'h3) ? INSTR_CYCLE_CLKS : 0);
		check("conv_len", 1'(n >= ex - 1 && n <= ex + 2), 1'b1);
		check("go_done", go_done, 1'b0);
		check("result", result, fmt ? {6'h00, target} : {target, 6'h00});
		for (m = 0; m < 1000 && discharge !== 1; m++) @(negedge clk);
		check("wait_len", 1'(m >= 2 * bit_period - 1 && m <= 2 * bit_period + 2), 1'b1);
		idle();
		check("resample", sample_enable, 1'b1);
		@(posedge clk) conv_done_clear <= 1;
		@(posedge clk) conv_done_clear <= 0;
		@(negedge clk) check("flag_clear", conv_done_flag, 1'b0);
		$display("conversion acq %0d tad %0d done", acq_n, bit_period);
	endtask
	task automatic abort_test;
		result_type keep;
		keep = 16'hA5C3;
		@(posedge clk) begin
			result_write <= 1;
			result_wdata <= keep;
			cfg.acq_time_select <= 3'h0;
			cfg.conv_clock_select <= 3'h0;
		end
		@(posedge clk) result_write <= 0;
		@(negedge clk) check("sw_write", result, keep);
		idle();
		pulse_go();
		repeat (8) @(posedge clk);
		go_clear <= 1;
		@(posedge clk) go_clear <= 0;
		repeat (3) @(negedge clk);
		check("abort_go", go_done, 1'b0);
		check("abort_res", result, keep);
		check("abort_flag", conv_done_flag, 1'b0);
		idle();
		check("abort_resample", sample_enable, 1'b1);
		$display("abort test done");
	endtask
	task automatic reset_test;
		idle();
		pulse_go();
		repeat (4) @(posedge clk);
		reset <= 1;
		portb_analog_reset_select <= 1'b0;
		repeat (8) @(posedge clk);
		reset <= 0;
		@(negedge clk);
		check("rst2_go", go_done, 1'b0);
		check("rst2_flag", conv_done_flag, 1'b0);
		check("rst2_res", result, 16'h0000);
		check("rst2_dac", dac_code, 10'h200);
		check("rst2_pcfg", pin_analog_config, PCFG_DIGITAL_RESET);
		idle();
		check("rst2_sample", sample_enable, 1'b1);
		$display("mid-run reset done");
	endtask
	task automatic trig(logic on, logic [3:0] mode, logic exp_go);
		@(posedge clk) begin
			cfg.converter_on <= on;
			cfg.compare_two_mode <= mode;
		end
		if (on) idle();
		else repeat (3) @(posedge clk);
		@(posedge clk) special_event <= 1;
		@(posedge clk) special_event <= 0;
		@(negedge clk) check("timer_reset", timer_reset, 1'b1);
		repeat (2) @(negedge clk);
		check("trig_go", go_done, exp_go);
		@(posedge clk) go_clear <= 1;
		@(posedge clk) go_clear <= 0;
		cfg.converter_on <= 1;
		idle();
		$display("trigger mode %h on %b done", mode, on);
	endtask
	task automatic port_test(logic [3:0] pc);
		logic [12:0] mask;
		mask = (pc <= 4'h2) ? 13'h0000 : (13'h1FFF & ~((13'h0001 << (15 - pc)) - 13'h0001));
		@(posedge clk) begin
			pin_cfg_write <= 1;
			pin_cfg_wdata <= pc;
			port_pins <= 13'h1FFF;
			cfg.channel_select <= pc;
		end
		@(posedge clk) pin_cfg_write <= 0;
		repeat (3) @(negedge clk);
		check("pcfg", pin_analog_config, pc);
		check("port_read", port_read_data, mask);
		check("channel", channel_out, pc);
		$display("port config %h done", pc);
	endtask
	// ---------------------------------------------------------------
	// main sequence and watchdog
	// ---------------------------------------------------------------
	initial begin
		reset = 1;
		cfg = '0;
		{pin_cfg_write, go_set, go_clear, result_write, conv_done_clear, special_event} = '0;
		pin_cfg_wdata = '0;
		result_wdata = '0;
		port_pins = '0;
		portb_analog_reset_select = 1'b1;
		target = 10'h2B7;
		repeat (8) @(posedge clk);
		reset <= 0;
		@(negedge clk);
		check("rst_go", go_done, 1'b0);
		check("rst_pcfg", pin_analog_config, PCFG_ANALOG_RESET);
		check("rst_dac", dac_code, 10'h200);
		@(posedge clk) cfg.converter_on <= 1;
		run_conv(3'h0, 0, 3'h0, 2, 1'b0);
		target = 10'h15A;
		run_conv(3'h2, 4, 3'h4, 4, 1'b1);
		run_conv(3'h1, 2, 3'h1, 8, 1'b0);
		target = 10'h3FF;
		run_conv(3'h3, 6, 3'h5, 16, 1'b1);
		target = 10'h001;
		run_conv(3'h4, 8, 3'h2, 32, 1'b0);
		run_conv(3'h5, 12, 3'h6, 64, 1'b1);
		target = 10'h2AA;
		run_conv(3'h6, 16, 3'h0, 2, 1'b1);
		run_conv(3'h7, 20, 3'h0, 2, 1'b0);
		run_conv(3'h0, 0, 3'h3, RC_TAD_CLKS, 1'b1);
		run_conv(3'h0, 0, 3'h7, RC_TAD_CLKS, 1'b0);
		abort_test();
		trig(1'b1, TRIGGER_MODE, 1'b1);
		trig(1'b1, 4'h9, 1'b0);
		trig(1'b0, TRIGGER_MODE, 1'b0);
		reset_test();
		port_test(4'hF);
		port_test(4'hD);
		port_test(4'h5);
		port_test(4'h2);
		summarize();
	end
	initial begin
		#(4 * 60000);
		failures++;
		summarize();
	end
endmodule
`default_nettype wire

// File: verilog/sar_adc_pkg.sv
// constants and types for the successive-approximation converter sequencer
// Overview of operation
// RL1 - a 10-bit conversion lasts eleven bit periods from start to result
// RL2 - bit period from clock select: 2,4,8,16,32,64 clocks or internal RC
// RL3 - zero acquisition with RC clock delays conversion by one instruction cycle
// RL4 - clearing go during conversion aborts it, result left untouched
// RL5 - result pair is writable, keeps last conversion or last software write
// RL6 - after completion or abort wait two bit periods, then sample again
// RL7 - acquisition select 010 samples four bit periods then converts
// RL8 - a discharge phase precedes every sampling phase
// RL9 - trigger with compare mode 1011 and converter on sets go
// RL10 - every trigger resets the associated timer counter
// RL11 - with converter off trigger is ignored but still resets the timer
// RL12 - port reads return zero for pins configured as analog
// RL13 - channel multiplexer ignores pin direction bits
// RL14 - software should not set go in the write that enables the converter
// RL15 - a fuse picks analog or digital reset value of pin configuration
// RL16 - software selects RC clock for conversions during sleep
// RL17 - software clears idle-on-sleep select before a sleep conversion
// RL18 - software uses RC clock when device clock is below one megahertz
// RL19 - with RC clock above one megahertz stay asleep whole conversion
// RL20 - keep the device clock source until a started conversion completes
// RL21 - completion loads result, clears go, sets done flag, resumes sampling
// RL22 - acquisition select encodes 0,2,4,6,8,12,16,20 bit periods
// RL23 - format bit set right-justifies result, clear left-justifies
// RL24 - device reset turns the converter off and aborts conversion
// RL25 - conversion resolves one bit per bit period, most significant first
package sar_adc_pkg;
	localparam int CLK_PERIOD_NS = 4;
	localparam int RC_TAD_NS = 1200;
	localparam int RC_TAD_CLKS = RC_TAD_NS / CLK_PERIOD_NS;
	localparam int INSTR_CYCLE_CLKS = 4;
	localparam int RESULT_BITS = 10;
	localparam int CONV_TADS = 11;
	localparam int WAIT_TADS = 2;
	localparam int DISCHARGE_TADS = 1;
	localparam int CHANNEL_COUNT = 13;
	localparam int TAD_CNT_W = 9;
	localparam int PHASE_CNT_W = 5;
	localparam logic [3:0] TRIGGER_MODE = 4'hB;
	localparam logic [2:0] ACQ_MANUAL = 3'h0;
	localparam logic [1:0] CLK_SEL_RC = 2'h3;
	localparam logic [3:0] PCFG_ANALOG_RESET = 4'h0;
	localparam logic [3:0] PCFG_DIGITAL_RESET = 4'h7;
	localparam logic [3:0] PCFG_ALL_ANALOG_MAX = 4'h2;
	localparam logic [3:0] PCFG_TOP = 4'hF;
	localparam int JUSTIFY_PAD = 16 - RESULT_BITS;

	typedef struct packed {
		logic converter_on;
		logic result_format;
		logic [2:0] acq_time_select;
		logic [2:0] conv_clock_select;
		logic [3:0] channel_select;
		logic [3:0] compare_two_mode;
	} cfg_type;

	typedef struct packed {
		logic [7:0] result_high;
		logic [7:0] result_low;
	} result_type;
endpackage

// File: verilog/sar_adc_sequencer.sv
// sequencer for the 10-bit successive-approximation converter
`timescale 1ns/1ns
`default_nettype none
module sar_adc_sequencer (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// configuration
	input wire sar_adc_pkg::cfg_type cfg,
	input wire logic portb_analog_reset_select,
	input wire logic pin_cfg_write,
	input wire logic [3:0] pin_cfg_wdata,
	output logic [3:0] pin_analog_config,
	// go/done control
	input wire logic go_set,
	input wire logic go_clear,
	output logic go_done,
	// result pair
	input wire logic result_write,
	input wire sar_adc_pkg::result_type result_wdata,
	output sar_adc_pkg::result_type result,
	// done flag
	input wire logic conv_done_clear,
	output logic conv_done_flag,
	// compare unit two trigger
	input wire logic special_event,
	output logic timer_reset,
	// analog front end
	input wire logic comparator_in,
	output logic [9:0] dac_code,
	output logic [3:0] channel_out,
	output logic sample_enable,
	output logic discharge,
	// port read path
	input wire logic [12:0] port_pins,
	output logic [12:0] port_read_data
);
	import sar_adc_pkg::*;

	//--------------------------------------------------------------
	// decoding
	//--------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_OFF, ST_DISCHARGE, ST_SAMPLE, ST_START_DELAY, ST_ACQUIRE, ST_CONVERT, ST_WAIT
	} state_type;

	function automatic logic [PHASE_CNT_W-1:0] acq_tads(input logic [2:0] sel);
		unique case (sel)
			3'h0: acq_tads = 5'h00;
			3'h1: acq_tads = 5'h02;
			3'h2: acq_tads = 5'h04;
			3'h3: acq_tads = 5'h06;
			3'h4: acq_tads = 5'h08;
			3'h5: acq_tads = 5'h0C;
			3'h6: acq_tads = 5'h10;
			3'h7: acq_tads = 5'h14;
		endcase
	endfunction

	function automatic logic [TAD_CNT_W-1:0] tad_limit(input logic [2:0] sel);
		unique case (sel)
			3'h0: tad_limit = 9'h001;
			3'h4: tad_limit = 9'h003;
			3'h1: tad_limit = 9'h007;
			3'h5: tad_limit = 9'h00F;
			3'h2: tad_limit = 9'h01F;
			3'h6: tad_limit = 9'h03F;
			default: tad_limit = TAD_CNT_W'(RC_TAD_CLKS - 1);
		endcase
	endfunction

	function automatic logic [CHANNEL_COUNT-1:0] analog_mask(input logic [3:0] pcfg);
		logic [4:0] count;
		count = (pcfg <= PCFG_ALL_ANALOG_MAX) ? 5'(CHANNEL_COUNT) : 5'(PCFG_TOP - pcfg);
		analog_mask = CHANNEL_COUNT'((14'h0001 << count) - 14'h0001);
	endfunction

	state_type state_reg, state_next;
	logic [TAD_CNT_W-1:0] tad_cnt_reg;
	logic [PHASE_CNT_W-1:0] phase_cnt_reg;
	logic [9:0] sar_reg;
	logic [3:0] bit_reg;
	logic go_reg, flag_reg, timer_reset_reg, sample_reg, discharge_reg;
	logic [3:0] pcfg_reg, chan_reg;
	logic [12:0] port_read_reg;
	result_type result_reg;

	wire rc_sel = (cfg.conv_clock_select[1:0] == CLK_SEL_RC); // RL2
	wire [TAD_CNT_W-1:0] tad_last = tad_limit(cfg.conv_clock_select); // RL2
	// a shorter select chosen mid-period ends the period at once instead of wrapping
	wire tad_tick = (tad_cnt_reg >= tad_last);
	wire delay_done = (tad_cnt_reg == TAD_CNT_W'(INSTR_CYCLE_CLKS - 1));
	wire [PHASE_CNT_W-1:0] acq_len = acq_tads(cfg.acq_time_select); // RL22
	wire trigger_start = special_event && cfg.converter_on
		&& (cfg.compare_two_mode == TRIGGER_MODE); // RL9 RL11
	wire go_start = (go_set || trigger_start) && state_reg == ST_SAMPLE;
	wire in_flight = state_reg inside {ST_START_DELAY, ST_ACQUIRE, ST_CONVERT};
	wire abort = go_clear && in_flight; // RL4
	logic [PHASE_CNT_W-1:0] phase_len;
	always_comb begin
		unique case (state_reg)
			ST_DISCHARGE: phase_len = PHASE_CNT_W'(DISCHARGE_TADS);
			ST_ACQUIRE: phase_len = acq_len;
			ST_CONVERT: phase_len = PHASE_CNT_W'(CONV_TADS);
			ST_WAIT: phase_len = PHASE_CNT_W'(WAIT_TADS);
			default: phase_len = PHASE_CNT_W'(1);
		endcase
	end
	wire phase_end = tad_tick && (phase_cnt_reg == phase_len - PHASE_CNT_W'(1));
	wire complete = state_reg == ST_CONVERT && phase_end && !go_clear
		&& cfg.converter_on; // RL1
	wire resolve = state_reg == ST_CONVERT && tad_tick
		&& phase_cnt_reg < PHASE_CNT_W'(RESULT_BITS);
	wire [15:0] justified = cfg.result_format ? {JUSTIFY_PAD'(0), sar_reg}
		: {sar_reg, JUSTIFY_PAD'(0)}; // RL23
	wire [9:0] bit_one = 10'h001 << bit_reg;
	wire [9:0] bit_below = (bit_reg == 4'h0) ? 10'h000 : (bit_one >> 1);

	//--------------------------------------------------------------
	// phase sequencing
	//--------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_OFF: state_next = ST_DISCHARGE; // RL8
			ST_DISCHARGE: if (phase_end) state_next = ST_SAMPLE; // RL8
			ST_SAMPLE: begin
				if (go_start && acq_len != 5'h00)
					state_next = ST_ACQUIRE; // RL7
				else if (go_start && rc_sel)
					state_next = ST_START_DELAY; // RL3
				else if (go_start)
					state_next = ST_CONVERT;
			end
			ST_START_DELAY: if (delay_done) state_next = ST_CONVERT; // RL3
			ST_ACQUIRE: if (phase_end) state_next = ST_CONVERT; // RL7
			ST_CONVERT: if (phase_end) state_next = ST_WAIT; // RL6
			ST_WAIT: if (phase_end) state_next = ST_DISCHARGE; // RL6 RL8
		endcase
		if (abort)
			state_next = ST_WAIT; // RL4 RL6
		if (!cfg.converter_on)
			state_next = ST_OFF;
	end

	wire restart = (state_next != state_reg);

	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= ST_OFF; // RL24
			tad_cnt_reg <= '0;
			phase_cnt_reg <= '0;
		end else begin
			state_reg <= state_next;
			tad_cnt_reg <= (restart || tad_tick) ? '0 : tad_cnt_reg + TAD_CNT_W'(1);
			phase_cnt_reg <= restart ? '0 : phase_cnt_reg + PHASE_CNT_W'(tad_tick);
		end
	end

	//--------------------------------------------------------------
	// successive approximation
	//--------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset || state_reg != ST_CONVERT) begin
			sar_reg <= 10'h200;
			bit_reg <= 4'h9;
		end else if (resolve) begin
			sar_reg <= (comparator_in ? sar_reg : (sar_reg & ~bit_one)) | bit_below; // RL25
			bit_reg <= bit_reg - 4'h1; // RL25
		end
	end

	//--------------------------------------------------------------
	// go, result and flag
	//--------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			go_reg <= 1'b0; // RL24
			flag_reg <= 1'b0;
			result_reg <= '0;
			timer_reset_reg <= 1'b0;
		end else begin
			if (!cfg.converter_on || complete || abort)
				go_reg <= 1'b0; // RL4 RL21
			else if (go_start)
				go_reg <= 1'b1; // RL9
			if (complete)
				result_reg <= justified; // RL21
			else if (result_write)
				result_reg <= result_wdata; // RL5
			if (complete)
				flag_reg <= 1'b1; // RL21
			else if (conv_done_clear)
				flag_reg <= 1'b0;
			timer_reset_reg <= special_event; // RL10 RL11
		end
	end

	//--------------------------------------------------------------
	// pins and front end
	//--------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			pcfg_reg <= portb_analog_reset_select ? PCFG_ANALOG_RESET
				: PCFG_DIGITAL_RESET; // RL15
			chan_reg <= '0;
			port_read_reg <= '0;
			sample_reg <= 1'b0;
			discharge_reg <= 1'b0;
		end else begin
			if (pin_cfg_write)
				pcfg_reg <= pin_cfg_wdata;
			chan_reg <= cfg.channel_select; // RL13
			port_read_reg <= port_pins & ~analog_mask(pcfg_reg); // RL12
			sample_reg <= state_next inside {ST_SAMPLE, ST_ACQUIRE, ST_START_DELAY};
			discharge_reg <= (state_next == ST_DISCHARGE); // RL8
		end
	end

	assign pin_analog_config = pcfg_reg;
	assign go_done = go_reg;
	assign result = result_reg;
	assign conv_done_flag = flag_reg;
	assign timer_reset = timer_reset_reg;
	assign dac_code = sar_reg;
	assign channel_out = chan_reg;
	assign sample_enable = sample_reg;
	assign discharge = discharge_reg;
	assign port_read_data = port_read_reg;

	//--------------------------------------------------------------
	// checks
	//--------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	logic [4:0] conv_ticks;
	always_ff @(posedge clk) begin
		if (reset || state_reg != ST_CONVERT)
			conv_ticks <= '0;
		else if (tad_tick)
			conv_ticks <= conv_ticks + 5'h01;
	end

	sequence div2_tick_s;
		state_reg == ST_CONVERT && cfg.conv_clock_select == 3'h0 && tad_tick;
	endsequence
	sequence enter_delay_s;
		state_reg == ST_SAMPLE ##1 state_reg == ST_START_DELAY;
	endsequence

	conv_length_a: assert property (complete |-> conv_ticks == 5'd10) // RL1
		else $error("conversion did not last eleven bit periods");
	div_two_a: assert property (div2_tick_s ##1 $stable(cfg) && state_reg == ST_CONVERT // RL2
		&& !go_clear |=> tad_tick)
		else $error("bit period of two clocks not kept");
	rc_delay_a: assert property (enter_delay_s // RL3
		##0 (cfg.converter_on && !go_clear) [*4] |=> state_reg == ST_CONVERT)
		else $error("start delay not one instruction cycle");
	delay_cause_a: assert property (enter_delay_s // RL3
		|-> $past(acq_len) == 5'h00 && $past(rc_sel))
		else $error("start delay without manual acquisition on the RC clock");
	abort_keep_a: assert property (go_clear && state_reg == ST_CONVERT // RL4
		&& cfg.converter_on && !result_write
		|=> $stable(result_reg) && !go_reg && state_reg == ST_WAIT)
		else $error("abort wrote result or missed wait");
	result_write_a: assert property (result_write && !complete // RL5
		|=> result_reg == $past(result_wdata))
		else $error("software result write lost");
	wait_end_a: assert property (state_reg == ST_WAIT && state_next != ST_WAIT // RL6
		|-> state_next inside {ST_DISCHARGE, ST_OFF} && (phase_end || abort
		|| !cfg.converter_on) && (!cfg.converter_on || phase_cnt_reg == 5'd1))
		else $error("post conversion wait wrong");
	acq_len_a: assert property (state_reg == ST_ACQUIRE && state_next == ST_CONVERT // RL7
		|-> phase_cnt_reg == acq_len - 5'd1)
		else $error("acquisition length wrong");
	acq_sampling_a: assert property (go_start && acq_len != 5'h00 && cfg.converter_on // RL7
		|=> state_reg == ST_ACQUIRE && sample_reg)
		else $error("acquisition did not keep sampling");
	discharge_first_a: assert property (state_reg != ST_SAMPLE ##1 state_reg == ST_SAMPLE // RL8
		|-> $past(state_reg) == ST_DISCHARGE && $past(discharge_reg))
		else $error("sampling without discharge");
	trigger_go_a: assert property (trigger_start && state_reg == ST_SAMPLE // RL9
		|=> go_reg ##0 timer_reset_reg)
		else $error("trigger did not set go");
	trigger_off_a: assert property (special_event && !cfg.converter_on // RL10 RL11
		|=> !go_reg && timer_reset_reg)
		else $error("trigger handling with converter off wrong");
	timer_pulse_a: assert property (special_event |=> timer_reset_reg) // RL10
		else $error("trigger did not reset the timer");
	port_zero_a: assert property (##1 ((port_read_reg // RL12
		& $past(analog_mask(pcfg_reg))) == 13'h0000))
		else $error("analog pin read not zero");
	converter_off_a: assert property (!cfg.converter_on // RL24
		|=> state_reg == ST_OFF && !go_reg && !discharge_reg)
		else $error("converter off did not stop the sequencer");
	sar_order_a: assert property (resolve // RL25
		|=> sar_reg[$past(bit_reg)] == $past(comparator_in))
		else $error("result bit not decided by the comparator");
	done_load_a: assert property (complete // RL21
		|=> flag_reg && !go_reg && result_reg == $past(justified) && state_reg == ST_WAIT)
		else $error("completion effects missing");
endmodule
`default_nettype wire
